/* File: dv/aps_frame_src.sv */
/*
 * Frame start trigger source in front of the sequencer.
 * Assumes the bench sets the gap before each pulse; gap zero is back to back.
 */
`timescale 1ns/100ps

module aps_frame_src (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_arm,
    input  wire logic [3:0] i_gap,
    output logic            o_frame
);
    logic [3:0] wait_q;

    // One-cycle pulses spaced by the gap; quiet while disarmed.
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_arm) begin
            o_frame <= 1'b0;
            wait_q  <= 4'h0;
        end else if (wait_q == 4'h0) begin
            o_frame <= 1'b1;
            wait_q  <= i_gap;
        end else begin
            o_frame <= 1'b0;
            wait_q  <= wait_q - 4'h1;
        end
    end
endmodule : aps_frame_src

/* File: dv/aps_sequencer_properties.sv */
/*
 * Port checker of the parameter set sequencer, bound to its top module.
 * Assumes one-cycle register strobes and one-cycle trigger pulses.
 */
`timescale 1ns/100ps
`include "aps_cfg.svh"

module aps_sequencer_properties (
    input wire logic                 I_SYS_CLK,
    input wire logic                 I_RESET,
    input wire logic [7:0]           I_ADDR,
    input wire logic [31:0]          I_WDATA,
    input wire logic                 I_WR,
    input wire logic                 I_FRAME_START,
    input wire logic                 I_AVERAGING_ON,
    input wire logic                 I_AUTO_FUNC_ON,
    input wire aps_pkg::aps_params_t O_ACTIVE,
    input wire logic                 O_ACQ_GO,
    input wire logic [5:0]           O_CUR_SET,
    input wire logic                 O_RUNNING
);
    logic inh;

    // Either inhibiting function blocks stepping outright.
    assign inh = I_AVERAGING_ON || I_AUTO_FUNC_ON;

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RESET);

    ////////////////////////////////////////////////////////////////////////
    // A trigger with no register write beside it.
    sequence s_trig;
        I_FRAME_START && !I_WR;
    endsequence
    // The stepper is switched off.
    sequence s_off;
        I_WR && I_ADDR == `APS_OFF_CTRL && !I_WDATA[`APS_CTRL_ON_BIT];
    endsequence
    // The stepper is switched on in automatic mode.
    sequence s_on;
        I_WR && I_ADDR == `APS_OFF_CTRL && I_WDATA[`APS_CTRL_ON_BIT]
            && I_WDATA[`APS_CTRL_MODE_LSB +: 2] == 2'h0;
    endsequence
    // A rewind lands on a trigger of a settled, running stepper.
    sequence s_rewind_trig;
        I_WR && I_ADDR == `APS_OFF_CMD && I_WDATA[`APS_CMD_REWIND_BIT]
            && I_FRAME_START && !inh && O_RUNNING && !$past(I_WR);
    endsequence

    AST_GO_AFTER_TRIG: assert property (I_FRAME_START |=> O_ACQ_GO)
        else $error("no acquire pulse after trigger");
    AST_GO_ONLY_TRIG: assert property (!I_FRAME_START |=> !O_ACQ_GO)
        else $error("acquire pulse without trigger");
    AST_INHIBIT: assert property (inh |=> !O_RUNNING)
        else $error("running while inhibited");
    AST_RUNNING: assert property (s_on ##1 !inh |=> O_RUNNING)
        else $error("not running after enable");
    AST_INHIBIT_NO_LOAD: assert property (s_trig and inh |=>
        $stable(O_CUR_SET) && $stable(O_ACTIVE))
        else $error("set loaded while inhibited");
    AST_REWIND: assert property (s_rewind_trig |=> O_CUR_SET == 6'h00)
        else $error("rewound trigger did not use set zero");
    AST_STEP: assert property (s_trig |=> O_CUR_SET == $past(O_CUR_SET)
        || O_CUR_SET == $past(O_CUR_SET) + 6'h01 || O_CUR_SET == 6'h00)
        else $error("set index jumped");
    AST_HOLD_SET: assert property (!I_FRAME_START && !I_WR |=>
        $stable(O_CUR_SET))
        else $error("set changed without trigger");
    AST_DISABLED: assert property (s_off ##1 s_trig |=>
        $stable(O_CUR_SET) && $stable(O_ACTIVE))
        else $error("set loaded while disabled");
endmodule : aps_sequencer_properties

bind aps_sequencer aps_sequencer_properties u_aps_sequencer_properties (
    .I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_FRAME_START(I_FRAME_START),
    .I_AVERAGING_ON(I_AVERAGING_ON), .I_AUTO_FUNC_ON(I_AUTO_FUNC_ON),
    .O_ACTIVE(O_ACTIVE), .O_ACQ_GO(O_ACQ_GO), .O_CUR_SET(O_CUR_SET),
    .O_RUNNING(O_RUNNING)
);

/* File: dv/aps_sequencer_tb.sv */
/*
 * Self-checking bench of the parameter set sequencer.
 * Assumes the frame source model and the bound checker are compiled too.
 */
`timescale 1ns/100ps
`include "aps_cfg.svh"

module aps_sequencer_tb;
    logic                 clk;
    logic                 rst;
    logic [7:0]           addr;
    logic [31:0]          wdata;
    logic                 wr;
    logic                 rd;
    logic                 frame;
    logic                 avg;
    logic                 autof;
    logic                 arm;
    logic [3:0]           gap;
    logic [31:0]          rdata;
    logic [5:0]           cur;
    logic                 go;
    logic                 run;
    aps_pkg::aps_params_t act;
    logic [159:0]         sw [64];
    logic [8:0]           rep [64];
    logic [159:0]         exp_act;
    logic [5:0]           exp_cur;
    logic [8:0]           exp_rem;
    logic                 first_m;
    logic                 on_m;
    logic                 chk_m;
    logic                 run_m;
    int                   bad_count;
    int                   checked;
    int                   cycles;
    int                   frames;
    int                   n;
    logic [31:0]          v;

    aps_sequencer u_aps_sequencer (.I_SYS_CLK(clk), .I_RESET(rst),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .I_FRAME_START(frame), .I_AVERAGING_ON(avg), .I_AUTO_FUNC_ON(autof),
        .O_RDATA(rdata), .O_ACTIVE(act), .O_ACQ_GO(go), .O_CUR_SET(cur),
        .O_RUNNING(run));
    aps_frame_src u_aps_frame_src (.i_clk(clk), .i_rst(rst), .i_arm(arm),
        .i_gap(gap), .o_frame(frame));

    ////////////////////////////////////////////////////////////////////////
    // Words of a set that was never saved.
    function automatic logic [159:0] def_set();
        return {`APS_DEF_W0, `APS_DEF_W1, `APS_DEF_W2, `APS_DEF_W3,
                `APS_DEF_W4};
    endfunction : def_set

    // Next index of the cycle, wrapping after the last set in use.
    function automatic logic [5:0] nxt(input logic [5:0] c);
        return (c == 6'(n - 1)) ? 6'h00 : c + 6'h01;
    endfunction : nxt

    task automatic check(input logic [159:0] s, input logic [159:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected at %0t: saw %0h want %0h", $time, s, e);
        end
    endtask : check

    task automatic end_sim();
        if (bad_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stands only in the cycle after the strobe.
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1 check(rdata, e);
    endtask : rd_reg

    task automatic run_frames(input int k);
        int t;
        t = frames + k;
        while (frames < t) begin
            @(posedge clk);
            gap <= 4'($urandom_range(3));
        end
    endtask : run_frames

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Cuts a hang short; the run needs well under this many cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            end_sim();
        end
    end

    // Reference model: compare the previous frame's load, then step.
    always @(posedge clk) begin
        if (go && chk_m) begin
            check(cur, exp_cur);
            check(act, exp_act);
        end
        run_m = on_m && !avg && !autof;
        chk_m = frame && run_m && !rst;
        if (wr && addr == `APS_OFF_CMD && wdata[`APS_CMD_REWIND_BIT])
            first_m = 1'b1;
        if (chk_m) begin
            if (first_m) begin
                exp_cur = 6'h00;
                exp_rem = rep[0] - 9'h001;
                first_m = 1'b0;
            end else if (exp_rem != 9'h000) begin
                exp_rem = exp_rem - 9'h001;
            end else begin
                exp_cur = nxt(exp_cur);
                exp_rem = rep[exp_cur] - 9'h001;
            end
            exp_act = sw[exp_cur];
            frames++;
        end
        if (!run_m)
            first_m = 1'b1;
        if (wr && addr == `APS_OFF_CTRL)
            on_m = wdata[`APS_CTRL_ON_BIT];
        if (rst)
            on_m = 1'b0;
    end

    initial begin
        {rst, wr, rd, avg, autof, arm, on_m, chk_m} = 8'h80;
        {addr, wdata, gap} = 44'h0;
        first_m = 1'b1;
        for (int i = 0; i < 64; i++) begin
            sw[i]  = def_set();
            rep[i] = 9'h001;
        end
        void'($urandom(84647));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1 check(act, def_set());
        rd_reg(`APS_OFF_TOTAL, 32'h0000_0001);
        wr_reg(`APS_OFF_TOTAL, 32'h0000_0000);
        rd_reg(`APS_OFF_TOTAL, 32'h0000_0001);
        wr_reg(`APS_OFF_TOTAL, 32'h0000_0041);
        rd_reg(`APS_OFF_TOTAL, 32'h0000_0040);
        wr_reg(`APS_OFF_REPEAT, 32'h0000_0000);
        rd_reg(`APS_OFF_REPEAT, 32'h0000_0001);
        wr_reg(`APS_OFF_POINTER, 32'h0000_003F);
        rd_reg(`APS_OFF_POINTER, 32'h0000_003F);
        rd_reg(8'h3C, 32'h0000_0000);
        // configured while off; last set left unsaved.
        n = 3 + $urandom_range(2);
        wr_reg(`APS_OFF_TOTAL, 32'(n));
        for (int i = 0; i < n - 1; i++) begin
            for (int k = 0; k < 5; k++) begin
                v = $urandom;
                wr_reg(8'(`APS_OFF_PARAM0 + 4 * k), v);
                sw[i][159 - 32 * k -: 32] = v;
            end
            rep[i] = (i == 0) ? 9'h100 : 9'(1 + (i > 1) * $urandom_range(2));
            // Set zero is written 300, which must clamp to 256.
            wr_reg(`APS_OFF_REPEAT, (i == 0) ? 32'h12C : 32'(rep[i]));
            wr_reg(`APS_OFF_POINTER, 32'(i));
            wr_reg(`APS_OFF_CMD, 32'h0000_0001);
        end
        // recall used for inspection only, before stepping.
        for (int j = 1; j < n; j += n - 2) begin
            wr_reg(`APS_OFF_POINTER, 32'(j));
            wr_reg(`APS_OFF_CMD, 32'h0000_0002);
            for (int k = 0; k < 5; k++)
                rd_reg(8'(`APS_OFF_PARAM0 + 4 * k),
                       sw[j][159 - 32 * k -: 32]);
        end
        wr_reg(`APS_OFF_CTRL, 32'h0000_0001);
        arm <= 1'b1;
        run_frames(300);
        // Back-to-back triggers, so the rewind lands on a trigger.
        repeat (4) @(posedge clk) gap <= 4'h0;
        wr_reg(`APS_OFF_CMD, 32'h0000_0004);
        run_frames(40);
        avg <= 1'b1;
        repeat (20) @(posedge clk);
        avg <= 1'b0;
        run_frames(20);
        autof <= 1'b1;
        repeat (20) @(posedge clk);
        autof <= 1'b0;
        run_frames(20);
        // Back-to-back triggers, so one follows the disable at once.
        repeat (4) @(posedge clk) gap <= 4'h0;
        wr_reg(`APS_OFF_CTRL, 32'h0000_0000);
        repeat (20) @(posedge clk);
        wr_reg(`APS_OFF_CTRL, 32'h0000_0001);
        run_frames(300);
        arm <= 1'b0;
        repeat (4) @(posedge clk);
        // A reset in mid-run must forget every saved set.
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wr_reg(`APS_OFF_PARAM0, ~`APS_DEF_W0);
        wr_reg(`APS_OFF_CMD, 32'h0000_0002);
        rd_reg(`APS_OFF_PARAM0, `APS_DEF_W0);
        rd_reg(`APS_OFF_TOTAL, 32'h0000_0001);
        end_sim();
    end
endmodule : aps_sequencer_tb

/* File: hdl/aps_cfg.svh */
/*
 * Constants of the automatic parameter set sequencer: register offsets,
 * field positions, limits, reset values and default parameter words.
 * Assumes an 8-bit byte address on the register port and 32-bit data.
 */
`ifndef APS_CFG_SVH
`define APS_CFG_SVH

// Register byte offsets.
`define APS_OFF_CTRL       8'h00
`define APS_OFF_TOTAL      8'h04
`define APS_OFF_POINTER    8'h08
`define APS_OFF_REPEAT     8'h0C
`define APS_OFF_CMD        8'h10
`define APS_OFF_STATUS     8'h14
`define APS_OFF_PARAM0     8'h20
`define APS_PARAM_WORDS    5

// Field positions.
`define APS_CTRL_ON_BIT    0
`define APS_CTRL_MODE_LSB  1
`define APS_CMD_SAVE_BIT   0
`define APS_CMD_RECALL_BIT 1
`define APS_CMD_REWIND_BIT 2
`define APS_ST_REMAIN_LSB  8
`define APS_ST_RUN_BIT     16
`define APS_ST_FIRST_BIT   17

// Limits and reset values.
`define APS_SET_SLOTS      64
`define APS_SET_MAX        7'h40
`define APS_RST_TOTAL      7'h01
`define APS_REPEAT_MAX     9'h100

// Parameter words held by a set that was never saved.
`define APS_DEF_W0         32'h0100_0100
`define APS_DEF_W1         32'h0000_0000
`define APS_DEF_W2         32'h1100_0000
`define APS_DEF_W3         32'h0000_0000
`define APS_DEF_W4         32'h0000_0001

`endif

/* File: hdl/aps_pkg.sv */
/*
 * Types of the automatic parameter set sequencer.
 * Assumes aps_cfg.svh is on the include path.
 */
`include "aps_cfg.svh"

package aps_pkg;

    // Stepping modes; only the automatic one is built here.
    typedef enum logic [1:0] {
        APS_MODE_AUTO,
        APS_MODE_CONTROLLED,
        APS_MODE_FREE
    } aps_mode_t;

    // Sequence-controlled parameters of the active configuration.
    typedef struct packed {
        logic [15:0] aoi_width;
        logic [15:0] aoi_height;
        logic [15:0] x_offset;
        logic [15:0] y_offset;
        logic [3:0]  bin_horiz;
        logic [3:0]  bin_vert;
        logic [7:0]  pixel_format;
        logic [3:0]  test_image;
        logic [3:0]  chunk_enables;
        logic [3:0]  delay_timebase;
        logic [3:0]  duration_timebase;
        logic [15:0] gain;
        logic [15:0] black_level;
        logic [15:0] timer_delay;
        logic [15:0] timer_duration;
    } aps_params_t;

    // One stored set: parameters plus repeat count less one.
    typedef struct packed {
        aps_params_t params;
        logic [7:0]  repeat_m1;
    } aps_set_t;

    // Whole state of the sequencer.
    typedef struct packed {
        logic                              stepper_on;
        aps_mode_t                         set_stepping_mode;
        logic [6:0]                        set_count_total;
        logic [5:0]                        set_pointer;
        aps_set_t                          active;
        aps_set_t [`APS_SET_SLOTS-1:0]     mem;
        logic [`APS_SET_SLOTS-1:0]         saved;
        logic                              first;
        logic                              running;
        logic [5:0]                        cur_set;
        logic [7:0]                        remain;
        logic                              acq_go;
        logic [31:0]                       rdata;
    } aps_state_t;

endpackage : aps_pkg

/* File: hdl/aps_sequencer.sv */
/*
 * Automatic parameter set sequencer: 64 stored sets of the
 * sequence-controlled parameters, stepped through at frame start triggers,
 * with save, recall and rewind commands on a plain register port.
 * Storage is flip-flops, so the 64 sets dominate the area of the block.
 * Assumes all inputs synchronous to I_SYS_CLK (40 MHz) and a register
 * master that issues one-cycle strobes, never write and read together.
 */
// Local design decisions: the register offsets and strobed register access.
// Operation
// - Step ascending through sets, wrap to zero.
// - Configurable set total, at most sixty-four.
// - Per-set repeat count, one to 256.
// - Set pointer takes index zero to 63.
// - Save copies active values into pointed set.
// - Never-saved sets in cycle give defaults.
// - Recall copies pointed set into active values.
// - Sets are volatile, cleared by reset.
// - First trigger after enable loads set zero.
// - Later triggers keep set until repeats used.
// - Rewind anytime makes next frame use zero.
// - Each set holds its own parameter values.
// - No stepping while averaging or auto on.
// - Set load never lowers frame rate.
`timescale 1ns/100ps
`include "aps_cfg.svh"

module aps_sequencer (
    input  wire logic                 I_SYS_CLK,
    input  wire logic                 I_RESET,
    input  wire logic [7:0]           I_ADDR,
    input  wire logic [31:0]          I_WDATA,
    input  wire logic                 I_WR,
    input  wire logic                 I_RD,
    input  wire logic                 I_FRAME_START,
    input  wire logic                 I_AVERAGING_ON,
    input  wire logic                 I_AUTO_FUNC_ON,
    output logic      [31:0]          O_RDATA,
    output aps_pkg::aps_params_t      O_ACTIVE,
    output logic                      O_ACQ_GO,
    output logic      [5:0]           O_CUR_SET,
    output logic                      O_RUNNING
);

    ////////////////////////////////////////////////////////////////////////
    // State and working signals.
    ////////////////////////////////////////////////////////////////////////

    aps_pkg::aps_state_t s_q;
    aps_pkg::aps_state_t s_d;

    // Parameters a never-saved set presents.
    localparam logic [159:0] DEF_PARAMS = {`APS_DEF_W0, `APS_DEF_W1,
                                           `APS_DEF_W2, `APS_DEF_W3,
                                           `APS_DEF_W4};

    logic                 run_now;
    logic                 wr_cmd;
    logic                 save_now;
    logic                 recall_now;
    logic                 rewind_now;
    logic                 load_now;
    logic [5:0]           last_idx;
    logic [5:0]           next_idx;
    logic [159:0]         act_words;
    aps_pkg::aps_set_t    rec_set;
    aps_pkg::aps_set_t    nxt_set;
    aps_pkg::aps_set_t    def_set;
    logic [8:0]           rep_val;
    logic [6:0]           tot_val;
    logic [31:0]          rd_val;
    logic [`APS_PARAM_WORDS-1:0] word_hit;

    ////////////////////////////////////////////////////////////////////////
    // Decoding of strobes and set lookups.
    ////////////////////////////////////////////////////////////////////////

    // Command bits are pulses; they are never stored, so they read as zero.
    assign wr_cmd     = I_WR && (I_ADDR == `APS_OFF_CMD);
    assign save_now   = wr_cmd && I_WDATA[`APS_CMD_SAVE_BIT];
    assign recall_now = wr_cmd && I_WDATA[`APS_CMD_RECALL_BIT];
    assign rewind_now = wr_cmd && I_WDATA[`APS_CMD_REWIND_BIT];

    // stepping inhibit
    // Averaging or the auto functions take the stepper out of play even if
    // software left it on; the other modes are not built and stay idle.
    assign run_now = s_q.stepper_on
                  && (s_q.set_stepping_mode == aps_pkg::APS_MODE_AUTO)
                  && !I_AVERAGING_ON
                  && !I_AUTO_FUNC_ON;

    // last cycle index
    // A total of one gives last index zero, so one set simply repeats.
    assign last_idx = 6'(s_q.set_count_total - 7'h01);

    assign def_set.params    = aps_pkg::aps_params_t'(DEF_PARAMS);
    assign def_set.repeat_m1 = 8'h00;

    assign rec_set = s_q.saved[s_q.set_pointer] ? s_q.mem[s_q.set_pointer]
                                                : def_set;

    // ascending with wrap
    // The first frame after enable or rewind takes set zero; otherwise an
    // exhausted set hands over to the next index, wrapping after the last.
    // The >= compare also catches a total lowered below the current set.
    always_comb begin
        if (s_q.first || rewind_now) begin
            next_idx = 6'h00;
            load_now = 1'b1;
        end else if (s_q.remain == 8'h00) begin
            next_idx = (s_q.cur_set >= last_idx) ? 6'h00
                                                 : 6'(s_q.cur_set + 6'h01);
            load_now = 1'b1;
        end else begin
            next_idx = s_q.cur_set;
            load_now = 1'b0;
        end
    end

    assign nxt_set = s_q.saved[next_idx] ? s_q.mem[next_idx] : def_set;

    // Active parameters viewed as plain words for the register port.
    assign act_words = s_q.active.params;

    // One address match per active parameter word; the read mux and the
    // write path share these, so the two can never disagree on the map.
    genvar g;
    generate
        for (g = 0; g < `APS_PARAM_WORDS; g = g + 1) begin : g_word
            assign word_hit[g] =
                (I_ADDR == 8'(`APS_OFF_PARAM0 + 4 * g));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Write data conditioning.
    ////////////////////////////////////////////////////////////////////////

    // repeat clamped 1..256
    // Out-of-range values are clamped rather than refused, so the stored
    // count is always legal and the step logic needs no error path.
    always_comb begin
        if (I_WDATA[8:0] == 9'h000 && I_WDATA[31:9] == 23'h0) begin
            rep_val = 9'h001;
        end else if (I_WDATA[31:9] != 23'h0 ||
                     I_WDATA[8:0] > `APS_REPEAT_MAX) begin
            rep_val = `APS_REPEAT_MAX;
        end else begin
            rep_val = I_WDATA[8:0];
        end
    end

    always_comb begin
        if (I_WDATA == 32'h0000_0000) begin
            tot_val = 7'h01;
        end else if (I_WDATA > {25'h0, `APS_SET_MAX}) begin
            tot_val = `APS_SET_MAX;
        end else begin
            tot_val = I_WDATA[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer.
    ////////////////////////////////////////////////////////////////////////

    // Unmapped offsets and the command register read as zero.
    // The parameter words show the active values, so while stepping they
    // show the stepped set rather than what software last wrote.
    always_comb begin
        rd_val = 32'h0000_0000;
        case (I_ADDR)
            `APS_OFF_CTRL: begin
                rd_val[`APS_CTRL_ON_BIT] = s_q.stepper_on;
                rd_val[`APS_CTRL_MODE_LSB +: 2] = s_q.set_stepping_mode;
            end
            `APS_OFF_TOTAL: begin
                rd_val[6:0] = s_q.set_count_total;
            end
            `APS_OFF_POINTER: begin
                rd_val[5:0] = s_q.set_pointer;
            end
            `APS_OFF_REPEAT: begin
                rd_val[8:0] = 9'(s_q.active.repeat_m1) + 9'h001;
            end
            `APS_OFF_STATUS: begin
                rd_val[5:0] = s_q.cur_set;
                rd_val[`APS_ST_REMAIN_LSB +: 8] = s_q.remain;
                rd_val[`APS_ST_RUN_BIT] = s_q.running;
                rd_val[`APS_ST_FIRST_BIT] = s_q.first;
            end
            default: begin
                for (int k = 0; k < `APS_PARAM_WORDS; k++) begin
                    if (word_hit[k]) begin
                        rd_val = act_words[159 - 32 * k -: 32];
                    end
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    ////////////////////////////////////////////////////////////////////////

    // Order inside this process sets priority: register writes, then the
    // commands, then the frame start load, which wins over a recall in the
    // same cycle because a frame in flight must get the stepped set.
    always_comb begin
        s_d        = s_q;
        s_d.acq_go = 1'b0;
        s_d.rdata  = 32'h0000_0000;

        // Plain register writes. Writes while running are taken as given;
        // keeping the stepper off while configuring is software's duty.
        // host configures while off
        if (I_WR) begin
            case (I_ADDR)
                `APS_OFF_CTRL: begin
                    s_d.stepper_on = I_WDATA[`APS_CTRL_ON_BIT];
                    s_d.set_stepping_mode =
                        aps_pkg::aps_mode_t'(I_WDATA[`APS_CTRL_MODE_LSB +: 2]);
                end
                `APS_OFF_TOTAL: begin
                    s_d.set_count_total = tot_val;
                end
                `APS_OFF_POINTER: begin
                    s_d.set_pointer = I_WDATA[5:0];
                end
                `APS_OFF_REPEAT: begin
                    s_d.active.repeat_m1 = 8'(rep_val - 9'h001);
                end
                default: begin
                    for (int k = 0; k < `APS_PARAM_WORDS; k++) begin
                        if (word_hit[k]) begin
                            s_d.active.params[159 - 32 * k -: 32] = I_WDATA;
                        end
                    end
                end
            endcase
        end

        // full parameter set stored
        // The whole active set, repeat count included, overwrites the slot.
        // Saving while the stepper runs stores whichever set is active then.
        if (save_now) begin
            s_d.mem[s_q.set_pointer]   = s_q.active;
            s_d.saved[s_q.set_pointer] = 1'b1;
        end

        // recall into active
        // Recall takes one cycle here, but a recall meant to switch sets
        // during acquisition is still a host misuse.
        // recall not for acquisition
        if (recall_now) begin
            s_d.active = rec_set;
        end

        if (rewind_now) begin
            s_d.first = 1'b1;
        end

        // disabled loads nothing
        // While idle the first-frame flag is held so that the next enable
        // always opens with set zero.
        // first frame set zero
        if (!run_now) begin
            s_d.first = 1'b1;
        end

        // single-cycle load
        // The set is loaded on the trigger edge itself and the go pulse leaves
        // with the new values, so stepping adds no frame-to-frame time.
        // A trigger while not running still pulses go, so frames are never
        // held back by the stepper.
        if (I_FRAME_START) begin
            s_d.acq_go = 1'b1;
            if (run_now) begin
                if (load_now) begin
                    s_d.active  = nxt_set;
                    s_d.cur_set = next_idx;
                    s_d.remain  = nxt_set.repeat_m1;
                    s_d.first   = 1'b0;
                end else begin
                    s_d.remain  = 8'(s_q.remain - 8'h01);
                end
            end
        end

        // Registered so the status bit and the port agree cycle for cycle.
        s_d.running = run_now;

        // Read data stand in the cycle after the strobe only.
        if (I_RD) begin
            s_d.rdata = rd_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.
    ////////////////////////////////////////////////////////////////////////

    // reset clears sets
    // Storage is plain flip-flops; reset forgets every saved set, which is
    // what a power cycle does to the volatile store as well.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            s_q                   <= '0;
            s_q.set_count_total   <= `APS_RST_TOTAL;
            s_q.set_stepping_mode <= aps_pkg::APS_MODE_AUTO;
            s_q.active.params     <= aps_pkg::aps_params_t'(DEF_PARAMS);
            s_q.first             <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all taken straight from the state register.
    ////////////////////////////////////////////////////////////////////////

    assign O_RDATA   = s_q.rdata;
    assign O_ACTIVE  = s_q.active.params;
    assign O_ACQ_GO  = s_q.acq_go;
    assign O_CUR_SET = s_q.cur_set;
    assign O_RUNNING = s_q.running;

endmodule : aps_sequencer
